// ### shared/surb_pkg.sv
// Package: address map, field positions and decode helpers of the upper register bank.
package surb_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    typedef logic [7:0] surb_byte_t;
    typedef logic [4:0] surb_idx_t;

    ////////////////////////////////////////////////////////////////////////////////
    localparam surb_byte_t ADDR_TAP_CONFIG = 8'h21;
    localparam surb_byte_t ADDR_TAP_SRC = 8'h22;
    localparam surb_byte_t ADDR_TAP_THR_X = 8'h23;
    localparam surb_byte_t ADDR_TAP_THR_Y = 8'h24;
    localparam surb_byte_t ADDR_TAP_THR_Z = 8'h25;
    localparam surb_byte_t ADDR_TAP_TIME_LIMIT = 8'h26;
    localparam surb_byte_t ADDR_TAP_LATENCY = 8'h27;
    localparam surb_byte_t ADDR_TAP_WINDOW = 8'h28;
    localparam surb_byte_t ADDR_SLEEP_COUNTER = 8'h29;
    localparam surb_byte_t ADDR_SYS_CTRL_ONE = 8'h2a;
    localparam surb_byte_t ADDR_SYS_CTRL_TWO = 8'h2b;
    localparam surb_byte_t ADDR_SYS_CTRL_THREE = 8'h2c;
    localparam surb_byte_t ADDR_IRQ_ENABLES = 8'h2d;
    localparam surb_byte_t ADDR_IRQ_ROUTING = 8'h2e;
    localparam surb_byte_t ADDR_OFFSET_X = 8'h2f;
    localparam surb_byte_t ADDR_OFFSET_Y = 8'h30;
    localparam surb_byte_t ADDR_OFFSET_Z = 8'h31;
    localparam surb_byte_t ADDR_IDENT = 8'h0d;
    localparam surb_byte_t ADDR_RSVD_LO = 8'h40;
    localparam surb_byte_t ADDR_DATA_FIRST = 8'h01;
    localparam surb_byte_t ADDR_DATA_LAST = 8'h06;
    localparam surb_byte_t ADDR_AFTER_WRAP = 8'h00;
    localparam surb_byte_t ADDR_PTR_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    localparam surb_byte_t REG_RESET = 8'h00;
    localparam surb_byte_t RSVD_READ = 8'h00;
    localparam int BANK_REGS = 17;
    localparam int SC1_ACTIVE = 0;
    localparam int SC1_FAST_READ = 1;
    localparam int SC1_RATE_LSB = 3;
    localparam int SC2_SOFT_RESET = 6;
    localparam int SC2_SELF_CHECK = 7;
    localparam int SC3_DRIVE = 0;
    localparam int SC3_POLARITY = 1;
    localparam int TAP_LATCH = 6;
    localparam int TAP_ACTIVE = 7;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic surb_in_bank(input surb_byte_t a);
        return (a >= ADDR_TAP_CONFIG) && (a <= ADDR_OFFSET_Z);
    endfunction

    function automatic surb_idx_t surb_idx(input surb_byte_t a);
        surb_byte_t d;
        d = a - ADDR_TAP_CONFIG;
        return d[4:0];
    endfunction

    function automatic logic surb_is_threshold(input surb_byte_t a);
        return (a >= ADDR_TAP_THR_X) && (a <= ADDR_TAP_THR_Z);
    endfunction

endpackage

// ### shared/surb_ptr_if.sv
// Interface: register pointer requests from the bank and the pointer value it returns.
`timescale 1ns/1ps
interface surb_ptr_if;
    logic load;
    logic [7:0] load_addr;
    logic rd;
    logic burst;
    logic stop;
    logic fifo_on;
    logic fast_read;
    logic [7:0] addr;

    modport bank (output load, load_addr, rd, burst, stop, fifo_on, fast_read, input addr);
    modport ptr (input load, load_addr, rd, burst, stop, fifo_on, fast_read, output addr);
endinterface

// ### rtl/surb_ptr.sv
// Register pointer with burst-read auto-increment and the irregular wrap addresses.
`timescale 1ns/1ps
module surb_ptr
    import surb_pkg::*;
(
    input wire logic ref_clk, // 50 MHz clock
    input wire logic arst_n,  // asynchronous reset, active low
    surb_ptr_if.ptr pif       // pointer requests and value
);

    surb_byte_t addr;
    surb_byte_t next_addr;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic surb_byte_t burst_next(input surb_byte_t a, input logic fifo_on,
                                             input logic fast);
        surb_byte_t inc;
        inc = a + 8'h01;
        if (a == ADDR_OFFSET_Z) begin
            burst_next = (!fifo_on && !fast) ? ADDR_IDENT : ADDR_AFTER_WRAP;
        end else if (fast && inc >= ADDR_DATA_FIRST && inc <= ADDR_DATA_LAST && !inc[0]) begin
            burst_next = inc + 8'h01;
        end else begin
            burst_next = inc;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // A stop outranks everything so that no stale address survives a frame.
    always_comb begin
        next_addr = addr;
        if (pif.stop) begin
            next_addr = ADDR_PTR_RESET;
        end else if (pif.load) begin
            next_addr = pif.load_addr;
        end else if (pif.rd && pif.burst) begin
            next_addr = burst_next(addr, pif.fifo_on, pif.fast_read);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr <= ADDR_PTR_RESET;
        end else begin
            addr <= next_addr;
        end
    end

    assign pif.addr = addr;

endmodule // surb_ptr

// ### rtl/surb_tap_src.sv
// Tap event source register: set by the detector, cleared on entry to active mode.
`timescale 1ns/1ps
module surb_tap_src
    import surb_pkg::*;
(
    input wire logic ref_clk,         // 50 MHz clock
    input wire logic arst_n,          // asynchronous reset, active low
    input wire logic go_active,       // standby to active pulse
    input wire logic ev_valid,        // detector event pulse
    input wire logic [6:0] ev_bits,   // detector event flags
    input wire logic latch_en,        // accumulate flags instead of replacing
    output surb_byte_t src            // register value
);

    surb_byte_t next_src;

    // An event in the same cycle as the clear wins, so no tap is lost.
    always_comb begin
        next_src = src;
        if (go_active) begin
            next_src = REG_RESET;
        end
        if (ev_valid) begin
            next_src[6:0] = (latch_en && !go_active) ? (src[6:0] | ev_bits) : ev_bits;
            next_src[TAP_ACTIVE] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            src <= REG_RESET;
        end else begin
            src <= next_src;
        end
    end

endmodule // surb_tap_src

// ### rtl/surb_bank.sv
// Upper register bank of the accelerometer: storage, write permissions, reads, pointer.
`timescale 1ns/1ps
module surb_bank
    import surb_pkg::*;
(
    input wire logic ref_clk,                  // 50 MHz clock
    input wire logic arst_n,                   // asynchronous reset, active low
    input wire logic reg_addr_load,            // host register address byte received
    input wire logic [7:0] reg_addr,           // register address to load
    input wire logic reg_wr,                   // write strobe at current pointer
    input wire logic [7:0] reg_wdata,          // write data
    input wire logic reg_rd,                   // read strobe at current pointer
    input wire logic reg_burst,                // read belongs to a burst
    input wire logic bus_stop,                 // stop condition seen on the bus
    input wire logic [7:0] low_rdata,          // read data of the lower map
    input wire logic [1:0] fifo_mode_select,   // FIFO mode bits of the FIFO setup
    input wire logic tap_ev_valid,             // tap detector event pulse
    input wire logic [6:0] tap_ev_bits,        // tap detector flags
    output surb_byte_t reg_rdata,              // read data, registered
    output logic reg_rvalid,                   // read data valid pulse
    output surb_byte_t reg_ptr,                // current register pointer
    output logic [8*BANK_REGS-1:0] cfg_image,  // all bank registers, lowest address first
    output logic active_mode,                  // active mode bit
    output logic fast_read_on,                 // fast read bit
    output logic [2:0] output_sample_rate,     // data rate selection
    output logic self_check_bit,               // self test request
    output logic irq_polarity,                 // interrupt pin polarity
    output logic irq_drive_type,               // interrupt pin drive type
    output logic [2:0] debounce_restart,       // per-axis debounce restart pulse
    output logic soft_reset_pulse              // soft reset request pulse
);

    ////////////////////////////////////////////////////////////////////////////////
    localparam int IDX_TAP_CONFIG = 0;
    localparam int IDX_SC1 = int'(ADDR_SYS_CTRL_ONE - ADDR_TAP_CONFIG);
    localparam int IDX_SC2 = int'(ADDR_SYS_CTRL_TWO - ADDR_TAP_CONFIG);
    localparam int IDX_SC3 = int'(ADDR_SYS_CTRL_THREE - ADDR_TAP_CONFIG);
    localparam int IDX_IRQ_EN = int'(ADDR_IRQ_ENABLES - ADDR_TAP_CONFIG);
    localparam int IDX_ROUTE = int'(ADDR_IRQ_ROUTING - ADDR_TAP_CONFIG);
    localparam int IDX_TIME = int'(ADDR_TAP_TIME_LIMIT - ADDR_TAP_CONFIG);
    localparam int IDX_OFF_Z = int'(ADDR_OFFSET_Z - ADDR_TAP_CONFIG);
    localparam int IDX_SRC = int'(ADDR_TAP_SRC - ADDR_TAP_CONFIG);

    surb_byte_t regs [BANK_REGS];
    surb_byte_t next_regs [BANK_REGS];
    surb_byte_t tap_src;
    surb_byte_t next_rdata;
    surb_byte_t thr_off;
    surb_idx_t wr_idx;
    logic next_rvalid;
    logic [2:0] next_debounce;
    logic next_soft;
    logic go_active;
    logic post_rst;

    surb_ptr_if pif ();

    ////////////////////////////////////////////////////////////////////////////////
    assign pif.load = reg_addr_load;
    assign pif.load_addr = reg_addr;
    assign pif.rd = reg_rd;
    assign pif.burst = reg_burst;
    assign pif.stop = bus_stop;
    assign pif.fifo_on = |fifo_mode_select;
    assign pif.fast_read = regs[IDX_SC1][SC1_FAST_READ];

    surb_ptr u_ptr (
        .ref_clk (ref_clk),
        .arst_n (arst_n),
        .pif (pif)
    );

    surb_tap_src u_tap_src (
        .ref_clk (ref_clk),
        .arst_n (arst_n),
        .go_active (go_active),
        .ev_valid (tap_ev_valid),
        .ev_bits (tap_ev_bits),
        .latch_en (regs[IDX_TAP_CONFIG][TAP_LATCH]),
        .src (tap_src)
    );

    ////////////////////////////////////////////////////////////////////////////////
    assign wr_idx = surb_idx(pif.addr);
    assign thr_off = pif.addr - ADDR_TAP_THR_X;

    // Writes never move the pointer; only loads, stops and burst reads do. Going to standby by
    // a write of the active bit touches nothing else, so every setting survives; a soft reset clears them all.
    always_comb begin
        next_regs = regs;
        next_debounce = 3'b000;
        next_soft = 1'b0;
        if (soft_reset_pulse) begin
            for (int i = 0; i < BANK_REGS; i++) begin
                next_regs[i] = REG_RESET;
            end
        end else if (reg_wr && surb_in_bank(pif.addr)) begin
            if (surb_is_threshold(pif.addr)) begin
                next_regs[wr_idx] = reg_wdata;
                next_debounce[thr_off[1:0]] = 1'b1;
            end else if (pif.addr == ADDR_TAP_SRC) begin
                next_regs[wr_idx] = regs[wr_idx];
            end else if (pif.addr == ADDR_SYS_CTRL_ONE && active_mode) begin
                next_regs[wr_idx][SC1_ACTIVE] = reg_wdata[SC1_ACTIVE];
            end else if (pif.addr == ADDR_SYS_CTRL_TWO) begin
                next_soft = reg_wdata[SC2_SOFT_RESET];
                if (!active_mode) begin
                    next_regs[wr_idx] = reg_wdata;
                    next_regs[wr_idx][SC2_SOFT_RESET] = 1'b0;
                end
            end else if (!active_mode) begin
                next_regs[wr_idx] = reg_wdata;
            end
        end
    end

    // Entry to active mode is only ever caused by a host write to the active bit.
    assign go_active = !active_mode && next_regs[IDX_SC1][SC1_ACTIVE];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < BANK_REGS; i++) begin
                regs[i] <= REG_RESET;
            end
        end else begin
            regs <= next_regs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The lower map owns every address below the bank and is passed through.
    always_comb begin
        next_rvalid = reg_rd;
        next_rdata = reg_rdata;
        if (reg_rd) begin
            if (pif.addr >= ADDR_RSVD_LO) begin
                next_rdata = RSVD_READ;
            end else if (pif.addr == ADDR_TAP_SRC) begin
                next_rdata = tap_src;
            end else if (surb_in_bank(pif.addr)) begin
                next_rdata = regs[wr_idx];
            end else begin
                next_rdata = low_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= REG_RESET;
            reg_rvalid <= 1'b0;
            debounce_restart <= 3'b000;
            soft_reset_pulse <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
            debounce_restart <= next_debounce;
            soft_reset_pulse <= next_soft;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    generate
        for (genvar g = 0; g < BANK_REGS; g++) begin : g_image
            if (g == IDX_SRC) begin : g_src
                assign cfg_image[8*g +: 8] = tap_src;
            end else begin : g_reg
                assign cfg_image[8*g +: 8] = regs[g];
            end
        end
    endgenerate

    assign reg_ptr = pif.addr;
    assign active_mode = regs[IDX_SC1][SC1_ACTIVE];
    assign fast_read_on = regs[IDX_SC1][SC1_FAST_READ];
    assign output_sample_rate = regs[IDX_SC1][SC1_RATE_LSB +: 3];
    assign self_check_bit = regs[IDX_SC2][SC2_SELF_CHECK];
    assign irq_polarity = regs[IDX_SC3][SC3_POLARITY];
    assign irq_drive_type = regs[IDX_SC3][SC3_DRIVE];

    ////////////////////////////////////////////////////////////////////////////////
    // Marks the first clock edge after reset release for the default checks.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            post_rst <= 1'b0;
        end else begin
            post_rst <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    keep_standby_a: assert property (
        $fell(active_mode) && !$past(soft_reset_pulse)
            |-> regs[IDX_TAP_CONFIG] == $past(regs[IDX_TAP_CONFIG])
            && regs[IDX_OFF_Z] == $past(regs[IDX_OFF_Z])
    ) else $error("bank changed on entry to standby");

    tap_clear_a: assert property (
        go_active && !tap_ev_valid |=> tap_src == REG_RESET
    ) else $error("tap source not cleared on activation");

    thr_anytime_a: assert property (
        reg_wr && surb_is_threshold(pif.addr) && !soft_reset_pulse
            |=> regs[$past(wr_idx)] == $past(reg_wdata)
    ) else $error("threshold write lost");

    debounce_y_a: assert property (
        reg_wr && pif.addr == ADDR_TAP_THR_Y && !soft_reset_pulse
            |=> debounce_restart == 3'b010 ##1 debounce_restart == 3'b000 || $past(reg_wr)
    ) else $error("debounce restart wrong");

    active_lock_a: assert property (
        active_mode && !soft_reset_pulse |=> $stable(regs[IDX_TIME]) && $stable(regs[IDX_SC3])
    ) else $error("locked register changed in active mode");

    single_hold_a: assert property (
        reg_rd && !reg_burst && !reg_addr_load && !bus_stop |=> $stable(pif.addr)
    ) else $error("pointer moved on single read");

    stop_clear_a: assert property (
        bus_stop |=> pif.addr == ADDR_PTR_RESET
    ) else $error("pointer kept after stop");

    burst_step_a: assert property (
        reg_rd && reg_burst && !reg_addr_load && !bus_stop
            && pif.addr >= ADDR_TAP_CONFIG && pif.addr < ADDR_OFFSET_Z
            |=> pif.addr == $past(pif.addr) + 8'h01
    ) else $error("burst pointer did not step by one");

    z_wrap_a: assert property (
        reg_rd && reg_burst && !reg_addr_load && !bus_stop && pif.addr == ADDR_OFFSET_Z
            && !pif.fifo_on && !fast_read_on |=> pif.addr == ADDR_IDENT
    ) else $error("no wrap to identification address");

    rsvd_zero_a: assert property (
        reg_rd && pif.addr >= ADDR_RSVD_LO |=> reg_rvalid && reg_rdata == RSVD_READ
    ) else $error("reserved read not zero");

    reset_dflt_a: assert property (
        !post_rst |-> regs[IDX_SC1] == REG_RESET && regs[IDX_IRQ_EN] == REG_RESET
            && regs[IDX_ROUTE] == REG_RESET
    ) else $error("control registers not zero after reset");

    fast_skip_a: assert property (
        reg_rd && reg_burst && fast_read_on && !reg_addr_load && !bus_stop
            && pif.addr == ADDR_DATA_FIRST |=> pif.addr == ADDR_DATA_FIRST + 8'h02
    ) else $error("fast read did not skip low byte");

    src_ro_a: assert property (
        reg_wr && pif.addr == ADDR_TAP_SRC && !tap_ev_valid && !go_active |=> $stable(tap_src)
    ) else $error("tap source changed by host write");

    soft_clear_a: assert property (
        soft_reset_pulse |=> regs[IDX_TAP_CONFIG] == REG_RESET && regs[IDX_SC2] == REG_RESET
    ) else $error("soft reset left bank contents");

    sc1_keep_a: assert property (
        active_mode && reg_wr && pif.addr == ADDR_SYS_CTRL_ONE && !soft_reset_pulse
            |=> regs[IDX_SC1][7:1] == $past(regs[IDX_SC1][7:1])
    ) else $error("locked control bits changed in active mode");

    debounce_quiet_a: assert property (
        !(reg_wr && surb_is_threshold(pif.addr)) |=> debounce_restart == 3'b000
    ) else $error("debounce restart without threshold write");

    tap_set_a: assert property (
        tap_ev_valid |=> tap_src[TAP_ACTIVE]
    ) else $error("tap event not recorded");

    wrap_seen_c: cover property (
        reg_rd && reg_burst && pif.addr == ADDR_OFFSET_Z ##1 pif.addr == ADDR_IDENT
    );

    thr_active_c: cover property (
        active_mode && reg_wr && surb_is_threshold(pif.addr)
    );

    activate_c: cover property (
        go_active ##[1:20] tap_ev_valid
    );

    soft_reset_c: cover property (
        soft_reset_pulse ##1 !active_mode
    );

    fast_burst_c: cover property (
        reg_rd && reg_burst && fast_read_on && pif.addr == ADDR_DATA_FIRST
    );

endmodule // surb_bank

// ### test/surb_host_model.sv
// Host-side model: pointer loads, writes, single and burst reads, stop conditions.
`timescale 1ns/1ps
module surb_host_model
    import surb_pkg::*;
(
    input wire logic ref_clk, // 50 MHz clock
    input wire logic reg_rvalid, // read data valid pulse
    input wire surb_byte_t reg_rdata, // read data
    output logic reg_addr_load, // pointer load request
    output logic [7:0] reg_addr, // pointer value
    output logic reg_wr, // write request
    output logic [7:0] reg_wdata, // write data
    output logic reg_rd, // read request
    output logic reg_burst, // read belongs to a burst
    output logic bus_stop // stop condition
);
    initial begin
        reg_addr_load = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        reg_burst = 1'b0;
        bus_stop = 1'b0;
    end

    task automatic go();
        @(posedge ref_clk);
        #1;
    endtask

    // Released lines show the inverse so that stale values are never mistaken for held ones.
    task automatic point(input surb_byte_t a);
        go();
        reg_addr_load = 1'b1;
        reg_addr = a;
        go();
        reg_addr_load = 1'b0;
        reg_addr = ~a;
    endtask

    task automatic write(input surb_byte_t a, input surb_byte_t d);
        if (a >= ADDR_RSVD_LO) return;
        point(a);
        reg_wr = 1'b1;
        reg_wdata = d;
        go();
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // A missing valid pulse hands back unknowns, which no expected value can match.
    task automatic burst(input surb_byte_t a, input int n, input logic b, output surb_byte_t q[$]);
        point(a);
        q = {};
        reg_rd = 1'b1;
        reg_burst = b;
        repeat (n) begin
            go();
            q.push_back((reg_rvalid === 1'b1) ? reg_rdata : 8'hxx);
        end
        reg_rd = 1'b0;
        reg_burst = ~b;
    endtask

    task automatic stop();
        go();
        bus_stop = 1'b1;
        go();
        bus_stop = 1'b0;
    endtask
endmodule // surb_host_model

// ### test/sensor_upper_register_bank_tb.sv
// Self-checking bench of the upper register bank: resets, permissions and pointer walks.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module sensor_upper_register_bank_tb
    import surb_pkg::*;
;
    logic ref_clk, arst_n, reg_addr_load, reg_wr, reg_rd, reg_burst, bus_stop, tap_ev_valid;
    logic [7:0] reg_addr, reg_wdata, low_rdata;
    logic [1:0] fifo_mode_select;
    logic [6:0] tap_ev_bits;
    surb_byte_t reg_rdata, reg_ptr;
    logic reg_rvalid, active_mode, fast_read_on, self_check_bit, irq_polarity, irq_drive_type;
    logic [8*BANK_REGS-1:0] cfg_image;
    logic [2:0] output_sample_rate, debounce_restart;
    logic soft_reset_pulse;
    int n_mismatch, n_compared;
    surb_byte_t q[$];

    surb_bank uut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr_load(reg_addr_load),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_burst(reg_burst), .bus_stop(bus_stop), .low_rdata(low_rdata),
        .fifo_mode_select(fifo_mode_select), .tap_ev_valid(tap_ev_valid),
        .tap_ev_bits(tap_ev_bits), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_ptr(reg_ptr), .cfg_image(cfg_image), .active_mode(active_mode),
        .fast_read_on(fast_read_on), .output_sample_rate(output_sample_rate),
        .self_check_bit(self_check_bit), .irq_polarity(irq_polarity),
        .irq_drive_type(irq_drive_type), .debounce_restart(debounce_restart),
        .soft_reset_pulse(soft_reset_pulse));

    surb_host_model hm (.ref_clk(ref_clk), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
        .reg_addr_load(reg_addr_load), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_burst(reg_burst), .bus_stop(bus_stop));

    always #10 ref_clk = ~ref_clk;

    // The lower map answers with a pattern of its address so that skipped bytes show up.
    always @(posedge ref_clk) begin
        #1;
        low_rdata = reg_ptr ^ 8'hc3;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tap(input logic [6:0] b);
        @(posedge ref_clk);
        #1;
        tap_ev_valid = 1'b1;
        tap_ev_bits = b;
        @(posedge ref_clk);
        #1;
        tap_ev_valid = 1'b0;
        tap_ev_bits = ~b;
    endtask

    task automatic t_reset();
        `CHK(cfg_image, '0)
        `CHK(output_sample_rate, 3'b000)
        `CHK(active_mode, 1'b0)
        for (int a = 8'h21; a <= 8'h31; a++) begin
            hm.burst(surb_byte_t'(a), 1, 1'b0, q);
            `CHK(q[0], REG_RESET)
            `CHK(reg_ptr, surb_byte_t'(a))
        end
        hm.burst(8'h40, 1, 1'b0, q);
        `CHK(q[0], RSVD_READ)
        hm.burst(8'h7f, 1, 1'b0, q);
        `CHK(q[0], RSVD_READ)
    endtask

    // Every writable register gets its own address as data; that keeps the part in standby.
    task automatic t_write_all();
        tap(7'h15);
        for (int a = 8'h21; a <= 8'h31; a++) hm.write(surb_byte_t'(a), surb_byte_t'(a));
        `CHK(output_sample_rate, 3'b101)
        `CHK(fast_read_on, 1'b1)
        hm.burst(ADDR_TAP_CONFIG, 17, 1'b1, q);
        for (int g = 0; g < 17; g++) begin
            `CHK(q[g], (g == 1) ? 8'h95 : surb_byte_t'(8'h21 + g))
        end
        `CHK(reg_ptr, ADDR_AFTER_WRAP)
        hm.write(ADDR_SYS_CTRL_TWO, 8'hab);
        hm.write(ADDR_SYS_CTRL_THREE, 8'h2f);
        `CHK(self_check_bit, 1'b1)
        `CHK(irq_polarity, 1'b1)
        `CHK(irq_drive_type, 1'b1)
    endtask

    task automatic t_active();
        hm.write(ADDR_SYS_CTRL_ONE, 8'h2b);
        `CHK(active_mode, 1'b1)
        hm.burst(ADDR_TAP_SRC, 1, 1'b0, q);
        `CHK(q[0], 8'h00)
        hm.write(ADDR_OFFSET_X, 8'hee);
        hm.burst(ADDR_OFFSET_X, 1, 1'b0, q);
        `CHK(q[0], 8'h2f)
        hm.write(ADDR_SYS_CTRL_THREE, 8'h00);
        `CHK(irq_polarity, 1'b1)
        for (int i = 0; i < 3; i++) begin
            hm.write(ADDR_TAP_THR_X + surb_byte_t'(i), surb_byte_t'(8'h70 + i));
            `CHK(debounce_restart, 3'(1 << i))
        end
        hm.write(ADDR_SYS_CTRL_ONE, 8'h00);
        `CHK(active_mode, 1'b0)
        `CHK(output_sample_rate, 3'b101)
        for (int i = 0; i < 3; i++) begin
            hm.burst(ADDR_TAP_THR_X + surb_byte_t'(i), 1, 1'b0, q);
            `CHK(q[0], surb_byte_t'(8'h70 + i))
        end
        `CHK(cfg_image[8*16 +: 8], 8'h31)
        tap(7'h15);
        hm.write(ADDR_TAP_SRC, 8'h00);
        hm.burst(ADDR_TAP_SRC, 1, 1'b0, q);
        `CHK(q[0], 8'h95)
    endtask

    // All FIFO-mode and fast-read combinations, over the wrap and over the data bytes.
    task automatic t_walk();
        logic [1:0] fm;
        logic f;
        int step;
        for (int i = 0; i < 8; i++) begin
            fm = i[1:0];
            f = i[2];
            fifo_mode_select = fm;
            hm.write(ADDR_SYS_CTRL_ONE, 8'h28 | {6'h00, f, 1'b0});
            hm.burst(ADDR_OFFSET_Y, 2, 1'b1, q);
            `CHK(q[0], 8'h30)
            `CHK(q[1], 8'h31)
            `CHK(reg_ptr, (fm == 2'b00 && !f) ? ADDR_IDENT : ADDR_AFTER_WRAP)
            hm.stop();
            `CHK(reg_ptr, ADDR_PTR_RESET)
            step = f ? 2 : 1;
            hm.burst(ADDR_DATA_FIRST, 3, 1'b1, q);
            for (int k = 0; k < 3; k++) begin
                `CHK(q[k], surb_byte_t'(1 + k * step) ^ 8'hc3)
            end
            `CHK(reg_ptr, surb_byte_t'(1 + 3 * step))
        end
    endtask

    task automatic t_soft();
        hm.write(ADDR_SYS_CTRL_ONE, 8'h01);
        hm.write(ADDR_SYS_CTRL_TWO, 8'h40);
        `CHK(soft_reset_pulse, 1'b1)
        hm.burst(ADDR_TAP_CONFIG, 1, 1'b0, q);
        `CHK(q[0], 8'h00)
        `CHK(self_check_bit, 1'b0)
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        fifo_mode_select = 2'b00;
        tap_ev_valid = 1'b0;
        tap_ev_bits = 7'h00;
        repeat (2) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_write_all();
        t_active();
        t_walk();
        t_soft();
        wrap_up();
    end

    // The whole run needs about three hundred cycles; sixty-odd times that means a hang.
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
endmodule // sensor_upper_register_bank_tb
